// ===== common/osc_defs.svh
`ifndef OSC_DEFS_SVH
`define OSC_DEFS_SVH

// Bus geometry
`define OSC_ADDR_W        18
`define OSC_DATA_W        32
`define OSC_IDX_W         16

// Register indices, byte address is four times the index
`define OSC_IDX_INT_CTRL  16'hFF9F
`define OSC_IDX_CLK_CTRL  16'hFFA0
`define OSC_IDX_MAIN_CTRL 16'hFFA2
`define OSC_IDX_STATUS    16'hFFA3
`define OSC_IDX_WAIT_SEL  16'hFFA4

// Reset values
`define OSC_MAIN_STOP_RST 1'h1
`define OSC_WAIT_SEL_RST  3'h5
`define OSC_STATUS_RST    5'h00
`define OSC_DIV_RST       3'h0

// Main oscillator control fields
`define OSC_MAIN_STOP_BIT 7

// Status register field positions
`define OSC_ST_2E16_BIT   0
`define OSC_ST_2E15_BIT   1
`define OSC_ST_2E14_BIT   2
`define OSC_ST_2E13_BIT   3
`define OSC_ST_2E11_BIT   4

// Clock control fields
`define OSC_CC_X1_REQ_BIT 0
`define OSC_CC_SRC_BIT    1
`define OSC_CC_DIV_LSB    4
`define OSC_CC_DIV_MSB    6
`define OSC_DIV_MAX       3'h4

// Internal oscillator control fields
`define OSC_IC_HS_STOP_BIT 0
`define OSC_IC_LS_STOP_BIT 1
`define OSC_IC_LS_OPT_BIT  6
`define OSC_IC_HS_8M_BIT   7

// Wait select codes
`define OSC_SEL_2E11      3'h1
`define OSC_SEL_2E13      3'h2
`define OSC_SEL_2E14      3'h3
`define OSC_SEL_2E15      3'h4
`define OSC_SEL_2E16      3'h5

// Oscillator cycle thresholds
`define OSC_CNT_W         17
`define OSC_CNT_2E11      17'h00800
`define OSC_CNT_2E13      17'h02000
`define OSC_CNT_2E14      17'h04000
`define OSC_CNT_2E15      17'h08000
`define OSC_CNT_2E16      17'h10000

`endif

// ===== common/osc_pkg.sv
`include "osc_defs.svh"

package osc_pkg;

  // Low-power sequencing states, Gray along run-stop-wait
  typedef enum logic [1:0] {
    OSC_RUN  = 2'b00,
    OSC_STOP = 2'b01,
    OSC_WAIT = 2'b11
  } osc_state_e;

  // APB request from the master
  typedef struct packed {
    logic                   psel;
    logic                   penable;
    logic                   pwrite;
    logic [`OSC_ADDR_W-1:0] paddr;
    logic [`OSC_DATA_W-1:0] pwdata;
  } osc_apb_req_s;

  // APB answer to the master
  typedef struct packed {
    logic [`OSC_DATA_W-1:0] prdata;
    logic                   pready;
    logic                   pslverr;
  } osc_apb_rsp_s;

endpackage

// ===== rtl/osc_stab_cnt.sv
`timescale 1ns/10ps
`include "osc_defs.svh"

// Saturating oscillator cycle counter
module osc_stab_cnt #(
  parameter int CNT_W = `OSC_CNT_W
) (
  input  wire logic             sys_clk,   // System clock
  input  wire logic             rst_b,     // Sync reset, active low
  input  wire logic             clear,     // Restart from zero
  input  wire logic             tick,      // One oscillator rising edge
  input  wire logic [CNT_W-1:0] limit,     // Saturation point
  output logic      [CNT_W-1:0] count_r,   // Edges counted
  output logic                  reached_r  // Count at limit
);

  logic [CNT_W-1:0] count_nxt;
  wire              below_lim = count_r < limit;

  assign count_nxt = clear ? '0 :
                     (tick && below_lim) ? count_r + {{(CNT_W-1){1'b0}}, 1'b1} :
                     count_r;

  // Count and reach flag
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      count_r   <= '0;
      reached_r <= 1'b0;
    end else begin
      count_r   <= count_nxt;
      reached_r <= !clear && (count_nxt >= limit);
    end
  end

endmodule

// ===== rtl/osc_stab_ctrl.sv
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/10ps
`include "osc_defs.svh"

// Summary of operation
// - Status clears on reset release, stop entry and main-oscillator stop write.
// - Flags set at 2^11,13,14,15,16 oscillator cycles; bit4 first; sticky.
// - Status is read-only; upper three bits read zero.
// - Counter stops at selected wait; flags never pass that threshold.
// - Select codes 1..5 map to 2^11,13,14,15,16; other codes forbidden.
// - Wait select resets to five, the 2^16 wait.
// - With main oscillator as CPU clock in resonator mode, hold CPU after wake until wait ends; external clock mode wakes without wait.
// - Only real oscillator edges are counted; start-up delay excluded.
// - Internal fast oscillator runs after reset; register can stop it only while the CPU runs on the main oscillator.
// - Option strap sets internal fast clock to 4 or 8 MHz.
// - Slow internal clock feeds watchdog and timer only, never the CPU.
// - Slow oscillator runs after reset; stoppable only when option allows.
// - CPU clock is the main clock divided by a prescaler.
// - Main-oscillator stop bit set stops oscillator; cleared enables it.
// - Read-only bit shows whether main clock is external or internal.
module osc_stab_ctrl (
  input  wire logic                 sys_clk,                // 25 MHz system clock
  input  wire logic                 rst_b,                  // Sync reset, active low
  input  osc_pkg::osc_apb_req_s     apb_req,                // APB request
  output osc_pkg::osc_apb_rsp_s     apb_rsp,                // APB answer
  input  wire logic                 resonator_main_osc,     // Resonator clock pin
  input  wire logic                 external_main_clock_in, // External clock pin
  input  wire logic                 opt_ext_clk_mode,       // Strap, external clock mode
  input  wire logic                 opt_hs_8mhz,            // Strap, fast clock 8 MHz
  input  wire logic                 opt_ls_stoppable,       // Strap, slow osc stoppable
  input  wire logic                 stop_entry,             // Stop instruction pulse
  input  wire logic                 stop_release,           // Wake event pulse
  output logic                      cpu_hold,               // CPU held in wait
  output logic                      main_osc_enable,        // Main oscillator enable
  output logic                      hs_osc_run,             // Fast internal osc run
  output logic                      ls_osc_run,             // Slow internal osc run
  output logic                      hs_freq_8mhz,           // Fast osc at 8 MHz
  output logic                      cpu_src_main,           // CPU on main oscillator
  output logic                      cpu_clk_en              // Prescaled CPU tick
);

  import osc_pkg::*;

  // Threshold for a wait select code
  function automatic logic [`OSC_CNT_W-1:0] sel_to_limit(input logic [2:0] sel);
    logic [`OSC_CNT_W-1:0] lim;
    case (sel)
      `OSC_SEL_2E11: lim = `OSC_CNT_2E11;
      `OSC_SEL_2E13: lim = `OSC_CNT_2E13;
      `OSC_SEL_2E14: lim = `OSC_CNT_2E14;
      `OSC_SEL_2E15: lim = `OSC_CNT_2E15;
      default:       lim = `OSC_CNT_2E16;
    endcase
    return lim;
  endfunction

  // Pin synchronisers and strap capture
  logic [1:0] x1_sync_r;
  logic [1:0] ext_sync_r;
  logic [2:0] opt_meta_r;
  logic [2:0] opt_sync_r;
  logic       osc_prev_r;
  logic [2:0] strap_done_r;
  logic       opt_ext_r;
  logic       opt_hs8_r;
  logic       opt_lsok_r;

  // Software visible state
  logic       main_en_r;
  logic [2:0] wait_sel_r;
  logic [4:0] status_r;
  logic       x1_req_r;
  logic [2:0] div_r;
  logic       hs_stop_r;
  logic       ls_stop_r;

  // Sequencing and outputs
  osc_state_e            state_r;
  osc_state_e            state_nxt;
  logic [`OSC_CNT_W-1:0] count_r;
  logic                  reached_r;
  logic                  src_main_r;
  logic [15:0]           pre_cnt_r;
  logic                  cpu_clk_en_r;
  logic                  cpu_hold_r;
  logic                  hs_run_r;
  logic                  ls_run_r;
  osc_apb_rsp_s          rsp_r;

  // Two-flop sampling of oscillator pins
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      x1_sync_r  <= 2'h0;
      ext_sync_r <= 2'h0;
    end else begin
      x1_sync_r  <= {x1_sync_r[0], resonator_main_osc};
      ext_sync_r <= {ext_sync_r[0], external_main_clock_in};
    end
  end

  // Two-flop sampling of option straps
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      opt_meta_r <= 3'h0;
      opt_sync_r <= 3'h0;
    end else begin
      opt_meta_r <= {opt_ls_stoppable, opt_hs_8mhz, opt_ext_clk_mode};
      opt_sync_r <= opt_meta_r;
    end
  end

  // Strap capture once synchronised after release
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      strap_done_r <= 3'h0;
      opt_ext_r    <= 1'b0;
      opt_hs8_r    <= 1'b0;
      opt_lsok_r   <= 1'b0;
    end else if (!strap_done_r[2]) begin
      strap_done_r <= {strap_done_r[1:0], 1'b1};
      opt_ext_r    <= opt_sync_r[0];
      opt_hs8_r    <= opt_sync_r[1];
      opt_lsok_r   <= opt_sync_r[2];
    end
  end

  // Selected oscillator level and its rising edge
  wire osc_level = opt_ext_r ? ext_sync_r[1] : x1_sync_r[1];

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      osc_prev_r <= 1'b0;
    end else begin
      osc_prev_r <= osc_level;
    end
  end

  wire osc_tick = osc_level && !osc_prev_r && main_en_r && state_r != OSC_STOP;

  // APB decode
  wire [`OSC_IDX_W-1:0] reg_idx   = apb_req.paddr[`OSC_ADDR_W-1:2];
  wire                  aligned   = apb_req.paddr[1:0] == 2'h0;
  wire                  hit_int   = aligned && reg_idx == `OSC_IDX_INT_CTRL;
  wire                  hit_clk   = aligned && reg_idx == `OSC_IDX_CLK_CTRL;
  wire                  hit_main  = aligned && reg_idx == `OSC_IDX_MAIN_CTRL;
  wire                  hit_stat  = aligned && reg_idx == `OSC_IDX_STATUS;
  wire                  hit_wsel  = aligned && reg_idx == `OSC_IDX_WAIT_SEL;
  wire                  hit_any   = hit_int | hit_clk | hit_main | hit_stat | hit_wsel;
  wire                  setup_ph  = apb_req.psel && !apb_req.penable;
  wire                  wr_commit = apb_req.psel && apb_req.penable && rsp_r.pready && apb_req.pwrite;
  wire [`OSC_DATA_W-1:0] wd       = apb_req.pwdata;

  // Write strobes per register
  wire wr_int  = wr_commit && hit_int;
  wire wr_clk  = wr_commit && hit_clk;
  wire wr_main = wr_commit && hit_main;
  wire wr_wsel = wr_commit && hit_wsel;

  wire stop_wr    = wr_main && wd[`OSC_MAIN_STOP_BIT];
  wire stab_clear = stop_entry || stop_wr || !main_en_r || state_r == OSC_STOP;

  wire [`OSC_CNT_W-1:0] cnt_limit = sel_to_limit(wait_sel_r);

  osc_stab_cnt #(
    .CNT_W (`OSC_CNT_W)
  ) u_cnt (
    .sys_clk   (sys_clk),
    .rst_b     (rst_b),
    .clear     (stab_clear),
    .tick      (osc_tick),
    .limit     (cnt_limit),
    .count_r   (count_r),
    .reached_r (reached_r)
  );

  wire [4:0] flag_now;
  assign flag_now[`OSC_ST_2E11_BIT] = count_r >= `OSC_CNT_2E11;
  assign flag_now[`OSC_ST_2E13_BIT] = count_r >= `OSC_CNT_2E13;
  assign flag_now[`OSC_ST_2E14_BIT] = count_r >= `OSC_CNT_2E14;
  assign flag_now[`OSC_ST_2E15_BIT] = count_r >= `OSC_CNT_2E15;
  assign flag_now[`OSC_ST_2E16_BIT] = count_r >= `OSC_CNT_2E16;

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      status_r <= `OSC_STATUS_RST;
    end else if (stab_clear) begin
      status_r <= `OSC_STATUS_RST;
    end else begin
      status_r <= status_r | flag_now;
    end
  end

  // stop bit, held as enable so the pin output is a flop
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      main_en_r <= !`OSC_MAIN_STOP_RST;
    end else if (wr_main) begin
      main_en_r <= !wd[`OSC_MAIN_STOP_BIT];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      wait_sel_r <= `OSC_WAIT_SEL_RST;
    end else if (wr_wsel) begin
      wait_sel_r <= wd[2:0];
    end
  end

  // Clock control: source request and divider
  wire [2:0] div_wr = wd[`OSC_CC_DIV_MSB:`OSC_CC_DIV_LSB];

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      x1_req_r <= 1'b0;
      div_r    <= `OSC_DIV_RST;
    end else if (wr_clk) begin
      x1_req_r <= wd[`OSC_CC_X1_REQ_BIT];
      div_r    <= (div_wr > `OSC_DIV_MAX) ? `OSC_DIV_MAX : div_wr;
    end
  end

  // fast osc stop bit, slow stop only if allowed
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      hs_stop_r <= 1'b0;
      ls_stop_r <= 1'b0;
    end else if (wr_int) begin
      hs_stop_r <= wd[`OSC_IC_HS_STOP_BIT] && src_main_r;
      ls_stop_r <= wd[`OSC_IC_LS_STOP_BIT] && opt_lsok_r;
    end
  end

  wire main_ready = main_en_r && (opt_ext_r || reached_r);

  // CPU chooses fast internal or main only
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      src_main_r <= 1'b0;
    end else if (!x1_req_r || !main_en_r) begin
      src_main_r <= 1'b0;
    end else if (main_ready) begin
      src_main_r <= 1'b1;
    end
  end

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      OSC_RUN: begin
        if (stop_entry) begin
          state_nxt = OSC_STOP;
        end
      end
      OSC_STOP: begin
        if (stop_release) begin
          state_nxt = (src_main_r && !opt_ext_r) ? OSC_WAIT : OSC_RUN;
        end
      end
      OSC_WAIT: begin
        if (reached_r) begin
          state_nxt = OSC_RUN;
        end
      end
      default: begin
        state_nxt = OSC_RUN;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      state_r <= OSC_RUN;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      cpu_hold_r <= 1'b0;
    end else begin
      cpu_hold_r <= state_nxt != OSC_RUN;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      hs_run_r <= 1'b1;
      ls_run_r <= 1'b1;
    end else begin
      hs_run_r <= !hs_stop_r && state_nxt != OSC_STOP;
      ls_run_r <= !ls_stop_r;
    end
  end

  wire [15:0] pre_mask = (16'h0001 << div_r) - 16'h0001;
  wire        pre_wrap = (pre_cnt_r & pre_mask) == pre_mask;

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      pre_cnt_r    <= 16'h0000;
      cpu_clk_en_r <= 1'b0;
    end else begin
      pre_cnt_r    <= pre_wrap ? 16'h0000 : pre_cnt_r + 16'h0001;
      cpu_clk_en_r <= pre_wrap && !cpu_hold_r && state_r != OSC_STOP;
    end
  end

  // Read data mux, status upper bits zero
  logic [`OSC_DATA_W-1:0] rd_mux;
  always_comb begin
    rd_mux = '0;
    if (hit_int) begin
      rd_mux[`OSC_IC_HS_STOP_BIT] = hs_stop_r;
      rd_mux[`OSC_IC_LS_STOP_BIT] = ls_stop_r;
      rd_mux[`OSC_IC_LS_OPT_BIT]  = opt_lsok_r;
      rd_mux[`OSC_IC_HS_8M_BIT]   = opt_hs8_r;
    end else if (hit_clk) begin
      rd_mux[`OSC_CC_X1_REQ_BIT]  = x1_req_r;
      rd_mux[`OSC_CC_SRC_BIT]     = src_main_r;
      rd_mux[`OSC_CC_DIV_MSB:`OSC_CC_DIV_LSB] = div_r;
    end else if (hit_main) begin
      rd_mux[`OSC_MAIN_STOP_BIT]  = !main_en_r;
    end else if (hit_stat) begin
      rd_mux[4:0] = status_r;
    end else if (hit_wsel) begin
      rd_mux[2:0] = wait_sel_r;
    end
  end

  // APB answer, ready in first access cycle
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      rsp_r <= '0;
    end else begin
      rsp_r.pready  <= setup_ph;
      rsp_r.pslverr <= setup_ph && !hit_any;
      rsp_r.prdata  <= (setup_ph && !apb_req.pwrite) ? rd_mux : '0;
    end
  end

  // Outputs straight from flops
  assign apb_rsp         = rsp_r;
  assign cpu_hold        = cpu_hold_r;
  assign main_osc_enable = main_en_r;
  assign hs_osc_run      = hs_run_r;
  assign ls_osc_run      = ls_run_r;
  assign hs_freq_8mhz    = opt_hs8_r;
  assign cpu_src_main    = src_main_r;
  assign cpu_clk_en      = cpu_clk_en_r;

endmodule

// ===== verification/osc_stab_ctrl_props.sv
`timescale 1ns/10ps
// Port-level checks for the stabilization controller
module osc_stab_ctrl_props (
  input wire logic             sys_clk,          // Clock
  input wire logic             rst_b,            // Reset, active low
  input osc_pkg::osc_apb_req_s apb_req,          // APB request
  input osc_pkg::osc_apb_rsp_s apb_rsp,          // APB answer
  input wire logic             opt_ext_clk_mode, // Strap, clock pin mode
  input wire logic             opt_hs_8mhz,      // Strap, fast osc rate
  input wire logic             opt_ls_stoppable, // Strap, slow osc stop
  input wire logic             stop_entry,       // Stop pulse
  input wire logic             stop_release,     // Wake pulse
  input wire logic             cpu_hold,         // CPU held
  input wire logic             main_osc_enable,  // Main osc enabled
  input wire logic             hs_osc_run,       // Fast osc run
  input wire logic             ls_osc_run,       // Slow osc run
  input wire logic             hs_freq_8mhz,     // Fast osc 8 MHz
  input wire logic             cpu_src_main,     // CPU on main osc
  input wire logic             cpu_clk_en        // CPU tick
);
  import osc_pkg::*;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  // Bus phase decode
  wire setup_w   = apb_req.psel && !apb_req.penable;
  wire done_w    = apb_req.psel && apb_req.penable && apb_rsp.pready;
  wire stat_rd_w = done_w && !apb_req.pwrite && (apb_req.paddr == 18'h3FE8C);
  wire main_wr_w = done_w && apb_req.pwrite && (apb_req.paddr == 18'h3FE88);
  // Stop taken in run state, wake taken in stop state
  sequence s_enter;
    stop_entry && !cpu_hold;
  endsequence
  sequence s_wake_main;
    stop_release && cpu_hold && !hs_osc_run && cpu_src_main && !opt_ext_clk_mode;
  endsequence
  chk_hold_enter: assert property (s_enter |=> cpu_hold)
    else $error("hold did not follow stop entry");
  chk_fast_stop: assert property (s_enter |=> !hs_osc_run)
    else $error("fast osc still running in stop");
  chk_hold_wait: assert property (s_wake_main |=> cpu_hold [*8])
    else $error("hold dropped before the wait");
  chk_fast_wake: assert property (s_wake_main |=> hs_osc_run)
    else $error("fast osc not restarted on wake");
  chk_main_write: assert property (main_wr_w |=> main_osc_enable == !$past(apb_req.pwdata[7]))
    else $error("main osc enable not per stop bit");
  chk_status_high: assert property (stat_rd_w |-> apb_rsp.prdata[31:5] == 27'h0)
    else $error("status upper bits not zero");
  chk_pready_pulse: assert property (setup_w |=> apb_rsp.pready)
    else $error("ready missing in access cycle");
  chk_ready_idle: assert property (!setup_w |=> !apb_rsp.pready)
    else $error("ready outside an access cycle");
  chk_slow_kept: assert property (!opt_ls_stoppable |-> ls_osc_run)
    else $error("slow osc stopped though not stoppable");
  chk_strap_rate: assert property ($stable(opt_hs_8mhz) [*8] |-> hs_freq_8mhz == opt_hs_8mhz)
    else $error("fast osc rate differs from strap");
  chk_tick_gated: assert property (cpu_hold [*2] |-> !cpu_clk_en)
    else $error("cpu tick while held");
endmodule

bind osc_stab_ctrl osc_stab_ctrl_props u_props (.sys_clk, .rst_b, .apb_req, .apb_rsp, .opt_ext_clk_mode,
  .opt_hs_8mhz, .opt_ls_stoppable, .stop_entry, .stop_release, .cpu_hold, .main_osc_enable, .hs_osc_run,
  .ls_osc_run, .hs_freq_8mhz, .cpu_src_main, .cpu_clk_en);

// ===== verification/osc_resonator_model.sv
`timescale 1ns/10ps
// Resonator on the main oscillator pin
module osc_resonator_model #(
  parameter int HALF_NS  = 100,  // Half period, 5 MHz
  parameter int START_NS = 20000 // Delay before oscillation builds up
) (
  input wire logic enable,  // Oscillator enabled
  output logic     osc_out  // Resonator clock
);
  // start delay, then clock in range
  initial begin
    osc_out = 1'b0;
    forever begin
      wait (enable === 1'b1);
      #(START_NS);
      while (enable === 1'b1) begin
        #(HALF_NS) osc_out = ~osc_out;
      end
      osc_out = 1'b0;
    end
  end
endmodule

// ===== verification/tb_osc_stabilization_counter.sv
`timescale 1ns/10ps
`include "osc_defs.svh"
module tb_osc_stabilization_counter;
  import osc_pkg::*;
  logic         sys_clk, rst_b, x1_pin, stop_entry, stop_release, err, opt_hs8, opt_lsok;
  logic         cpu_hold, main_osc_enable, hs_osc_run, ls_osc_run, hs_freq_8mhz, cpu_src_main, cpu_clk_en;
  logic [31:0]  rd;
  logic [2:0]   sel;
  osc_apb_req_s req;
  osc_apb_rsp_s rsp;
  int           error_cnt, n_compared, n;

  osc_stab_ctrl dut (.sys_clk(sys_clk), .rst_b(rst_b), .apb_req(req), .apb_rsp(rsp),
    .resonator_main_osc(x1_pin), .external_main_clock_in(1'b0), .opt_ext_clk_mode(1'b0),
    .opt_hs_8mhz(opt_hs8), .opt_ls_stoppable(opt_lsok), .stop_entry(stop_entry), .stop_release(stop_release),
    .cpu_hold(cpu_hold), .main_osc_enable(main_osc_enable), .hs_osc_run(hs_osc_run),
    .ls_osc_run(ls_osc_run), .hs_freq_8mhz(hs_freq_8mhz), .cpu_src_main(cpu_src_main),
    .cpu_clk_en(cpu_clk_en));
  osc_resonator_model #(.HALF_NS(100), .START_NS(20000)) u_xtal (.enable(main_osc_enable), .osc_out(x1_pin));

  // Clock
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  // Compare helpers
  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: word %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_bit(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: bit %b expected %b", $time, got, exp);
    end
  endtask

  // Flags expected once the selected wait has elapsed
  function automatic logic [31:0] exp_flags(input logic [2:0] code);
    case (code)
      3'h1: return 32'h10;
      3'h2: return 32'h18;
      3'h3: return 32'h1C;
      3'h4: return 32'h1E;
      default: return 32'h1F;
    endcase
  endfunction

  // One APB transfer, waits for ready
  task automatic apb(input logic wr, input logic [15:0] idx, input logic [31:0] wd);
    int k;
    @(posedge sys_clk);
    req <= '{1'b1, 1'b0, wr, {idx, 2'b00}, wd};
    @(posedge sys_clk);
    req.penable <= 1'b1;
    k = 0;
    do begin
      @(posedge sys_clk);
      k++;
    end while (rsp.pready !== 1'b1 && k < 16);
    rd = rsp.prdata;
    err = rsp.pslverr;
    if (k >= 16) cmp_bit(1'b0, 1'b1);
    req <= '0;
  endtask

  // One-cycle stop or wake pulse
  task automatic pulse(input logic wake);
    @(posedge sys_clk);
    if (wake) stop_release <= 1'b1;
    else stop_entry <= 1'b1;
    @(posedge sys_clk);
    stop_entry <= 1'b0;
    stop_release <= 1'b0;
  endtask

  task automatic give_verdict;
    $display("compared %0d, errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Watchdog
  initial begin
    #2400000;
    error_cnt++;
    give_verdict;
  end

  // Main sequence
  initial begin
    req = '0;
    stop_entry = 1'b0;
    stop_release = 1'b0;
    rst_b = 1'b0;
    error_cnt = 0;
    n_compared = 0;
    void'($urandom(32'hDB7EFED1));
    opt_hs8 <= 1'($urandom);
    opt_lsok <= 1'($urandom);
    repeat (3) @(posedge sys_clk);
    rst_b <= 1'b1;
    apb(0, `OSC_IDX_WAIT_SEL, 32'h0);
    cmp_word(rd, 32'h5);
    apb(1, `OSC_IDX_STATUS, 32'hFF);
    apb(0, `OSC_IDX_STATUS, 32'h0);
    cmp_word(rd, 32'h0);
    cmp_bit(main_osc_enable, 1'b0);
    apb(0, 16'h0010, 32'h0);
    cmp_bit(err, 1'b1);
    cmp_bit(hs_freq_8mhz, opt_hs8);
    apb(1, `OSC_IDX_INT_CTRL, 32'h3);
    @(negedge sys_clk);
    cmp_bit(hs_osc_run, 1'b1);
    apb(0, `OSC_IDX_INT_CTRL, 32'h0);
    cmp_word(rd, {24'h0, opt_hs8, opt_lsok, 4'h0, opt_lsok, 1'b0});
    cmp_bit(ls_osc_run, !opt_lsok);
    // Every wait code in order, then random ones
    for (int i = 1; i < 10; i++) begin
      sel = (i < 6) ? 3'(i) : 3'($urandom_range(5, 1));
      apb(1, `OSC_IDX_WAIT_SEL, {29'h0, sel});
      apb(0, `OSC_IDX_WAIT_SEL, 32'h0);
      cmp_word(rd, {29'h0, sel});
    end
    apb(1, `OSC_IDX_WAIT_SEL, 32'h1);
    apb(1, `OSC_IDX_MAIN_CTRL, 32'h0);
    @(negedge sys_clk);
    cmp_bit(main_osc_enable, 1'b1);
    n = 0;
    do begin
      apb(0, `OSC_IDX_STATUS, 32'h0);
      n++;
    end while (rd === 32'h0 && n < 6000);
    cmp_word(rd, exp_flags(3'h1));
    repeat (12000) @(posedge sys_clk);
    apb(0, `OSC_IDX_STATUS, 32'h0);
    cmp_word(rd, exp_flags(3'h1));
    // CPU onto main oscillator, then stop and wake
    apb(1, `OSC_IDX_CLK_CTRL, 32'h1);
    repeat (4) @(posedge sys_clk);
    apb(0, `OSC_IDX_CLK_CTRL, 32'h0);
    cmp_word(rd & 32'h2, 32'h2);
    cmp_bit(cpu_src_main, 1'b1);
    cmp_bit(cpu_clk_en, 1'b1);
    pulse(1'b0);
    @(negedge sys_clk);
    cmp_bit(cpu_hold, 1'b1);
    apb(0, `OSC_IDX_STATUS, 32'h0);
    cmp_word(rd, 32'h0);
    cmp_bit(cpu_clk_en, 1'b0);
    repeat ($urandom_range(40, 5)) @(posedge sys_clk);
    pulse(1'b1);
    repeat (1000) @(posedge sys_clk);
    cmp_bit(cpu_hold, 1'b1);
    n = 0;
    while (cpu_hold !== 1'b0 && n < 15000) begin
      @(posedge sys_clk);
      n++;
    end
    cmp_bit(cpu_hold, 1'b0);
    apb(0, `OSC_IDX_STATUS, 32'h0);
    cmp_word(rd, exp_flags(3'h1));
    // Stop bit clears the flags
    apb(1, `OSC_IDX_MAIN_CTRL, 32'h80);
    apb(0, `OSC_IDX_STATUS, 32'h0);
    cmp_word(rd, 32'h0);
    cmp_bit(cpu_src_main, 1'b0);
    give_verdict;
  end
endmodule
